// ==== src/rmii_defines.vh ====
// Constants for the RMII MAC-side port
`ifndef RMII_DEFINES_VH
`define RMII_DEFINES_VH
`define RMII_DIBIT_W      2
`define RMII_BYTE_W       8
`define RMII_DIBITS_BYTE  3'h4
`define RMII_FIFO_DEPTH   8
`define RMII_REF_MHZ      50
`define RMII_CLK_MHZ      100
`define RMII_PREAMBLE_LEN 4'h7
`define RMII_SFD_BYTE     8'hd5
`define RMII_PRE_BYTE     8'h55
`define RMII_IDLE_DIBIT   2'h0
`endif

// ==== src/rmii_fifo.v ====
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rmii_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             ce_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_r;
  reg [AW:0]      rd_ptr_r;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  // Pointer comparison with an extra wrap bit
  assign empty       = (wr_ptr_r == rd_ptr_r);
  assign full        = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem[rd_ptr_r[AW-1:0]];
  assign push        = in_valid_i & ~full & ce_i;
  assign pop         = out_ready_i & ~empty & ce_i;

  // Storage and pointers
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr_r[AW-1:0]] <= in_data_i;
        wr_ptr_r              <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule // rmii_fifo

// ==== src/rmii_mac_side.v ====
// MAC-side RMII port: transmit serialiser with FIFO, receive deserialiser
// Overview of operation
// - All link timing comes from the continuous 50 MHz reference clock input.
// - Device drives a reference clock out for the attached PHY or switch.
// - Transmit enable rises with first preamble dibit, stays high while dibits remain.
// - Transmit data is a 2-bit dibit, bit 1 most significant, reference-clock synchronous.
// - Receive dibits count only while carrier valid is high; others are discarded.
// - Receive error high any cycle marks the current frame as errored.
// - Receive data is a 2-bit dibit, bit 1 most significant, sampled on reference clock.
`timescale 1ns/1ps
`include "rmii_defines.vh"
module rmii_mac_side #(
  parameter FIFO_DEPTH = `RMII_FIFO_DEPTH,
  parameter FIFO_AW    = 3
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       ce_i,
  input  wire       ref_clk_i,
  output wire       ref_clock_out_o,
  output reg        tx_en_o,
  output reg  [1:0] txd_o,
  input  wire       carrier_valid_pin_i,
  input  wire       rx_error_pin_i,
  input  wire [1:0] rxd_i,
  input  wire [7:0] tx_data_i,
  input  wire       tx_valid_i,
  input  wire       tx_last_i,
  output wire       tx_ready_o,
  output reg  [7:0] rx_data_o,
  output reg        rx_valid_o,
  output reg        rx_frame_end_o,
  output reg        rx_frame_err_o
);
  // Transmit states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_PRE  = 2'b01;
  localparam [1:0] ST_DATA = 2'b10;

  reg  [2:0] refclk_sync_r;
  reg  [1:0] crs_sync_r;
  reg  [1:0] rxd_s1_r;
  reg  [1:0] rxd_s2_r;
  reg  [1:0] rxer_sync_r;
  wire       ref_rise;
  wire       crs_s;
  wire [8:0] fifo_out;
  wire       fifo_valid;
  reg        fifo_pop;
  reg  [1:0] st_r;
  reg  [1:0] st_nxt;
  reg  [3:0] pre_cnt_r;
  reg  [7:0] tx_sh_r;
  reg        tx_last_r;
  reg  [1:0] tx_dib_r;
  reg  [7:0] rx_sh_r;
  reg  [1:0] rx_dib_r;
  reg        rx_err_r;
  reg        rx_act_r;
  reg  [8:0] fifo_hold_r;
  reg        fifo_pop_hold_r;

  // Extract dibit k (0 = least significant) of a byte
  function [1:0] dibit_of;
    input [7:0] b;
    input [1:0] k;
    begin
      dibit_of = b[{k, 1'b0} +: 2];
    end
  endfunction

  // Reference clock forwarded to the PHY
  assign ref_clock_out_o = refclk_sync_r[1];

  // Two-flop synchronisers for all link pins, third stage finds ref clock edges
  always @(posedge clk_i) begin
    if (rst_i) begin
      refclk_sync_r <= 3'h0;
      crs_sync_r    <= 2'h0;
      rxd_s1_r      <= 2'h0;
      rxd_s2_r      <= 2'h0;
      rxer_sync_r   <= 2'h0;
    end else if (ce_i) begin
      refclk_sync_r <= {refclk_sync_r[1:0], ref_clk_i};
      crs_sync_r    <= {crs_sync_r[0], carrier_valid_pin_i};
      rxd_s1_r      <= rxd_i;
      rxd_s2_r      <= rxd_s1_r;
      rxer_sync_r   <= {rxer_sync_r[0], rx_error_pin_i};
    end
  end

  assign ref_rise = refclk_sync_r[1] & ~refclk_sync_r[2];
  assign crs_s    = crs_sync_r[1];

  // Transmit byte FIFO, last flag carried as bit 8
  rmii_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_tx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_data_i   ({tx_last_i, tx_data_i}),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  // Transmit next state and FIFO pop
  always @* begin
    st_nxt   = st_r;
    fifo_pop = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (ref_rise && fifo_valid) begin
          st_nxt = ST_PRE;
        end
      end
      ST_PRE: begin
        // Delimiter's last dibit goes out: fetch the first payload byte
        if (ref_rise && tx_dib_r == 2'h3 && pre_cnt_r == 4'h0) begin
          st_nxt   = ST_DATA;
          fifo_pop = fifo_valid;
        end
      end
      ST_DATA: begin
        // Prefetch the next byte while the current one finishes
        if (ref_rise && tx_dib_r == 2'h3 && !tx_last_r) begin
          fifo_pop = fifo_valid;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Transmit serialiser: preamble, start delimiter, then payload bytes
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_r      <= ST_IDLE;
      pre_cnt_r <= 4'h0;
      tx_sh_r   <= 8'h00;
      tx_last_r <= 1'b0;
      tx_dib_r  <= 2'h0;
      tx_en_o   <= 1'b0;
      txd_o     <= `RMII_IDLE_DIBIT;
    end else if (ce_i) begin
      st_r <= st_nxt;
      if (ref_rise) begin
        case (st_r)
          ST_IDLE: begin
            if (fifo_valid) begin
              tx_en_o   <= 1'b1;
              txd_o     <= dibit_of(`RMII_PRE_BYTE, 2'h0);
              tx_dib_r  <= 2'h1;
              pre_cnt_r <= `RMII_PREAMBLE_LEN;
              tx_sh_r   <= `RMII_PRE_BYTE;
            end
          end
          ST_PRE: begin
            // All four dibits of every preamble byte and of the delimiter go out;
            // an underrun after the delimiter is caught at the first data dibit
            txd_o    <= dibit_of(tx_sh_r, tx_dib_r);
            tx_dib_r <= tx_dib_r + 2'h1;
            if (tx_dib_r == 2'h3) begin
              pre_cnt_r <= pre_cnt_r - 4'h1;
              tx_sh_r   <= (pre_cnt_r == 4'h1) ? `RMII_SFD_BYTE : `RMII_PRE_BYTE;
            end
          end
          ST_DATA: begin
            if (tx_dib_r == 2'h3 && tx_last_r) begin
              txd_o    <= dibit_of(tx_sh_r, 2'h3);
              tx_dib_r <= 2'h0;
            end else if (tx_dib_r == 2'h3) begin
              txd_o <= dibit_of(tx_sh_r, 2'h3);
              if (!fifo_valid) begin
                tx_last_r <= 1'b1; // Underrun: close after this byte
              end
              tx_dib_r <= 2'h0;
            end else if (tx_dib_r == 2'h0) begin
              if (fifo_pop_hold_r) begin
                tx_sh_r   <= fifo_hold_r[7:0];
                tx_last_r <= fifo_hold_r[8];
                txd_o     <= dibit_of(fifo_hold_r[7:0], 2'h0);
                tx_dib_r  <= 2'h1;
              end else begin
                tx_en_o  <= 1'b0;
                txd_o    <= `RMII_IDLE_DIBIT;
                st_r     <= ST_IDLE;
              end
            end else begin
              txd_o    <= dibit_of(tx_sh_r, tx_dib_r);
              tx_dib_r <= tx_dib_r + 2'h1;
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Holding stage for the byte popped at the end of the previous byte
  always @(posedge clk_i) begin
    if (rst_i) begin
      fifo_hold_r     <= 9'h000;
      fifo_pop_hold_r <= 1'b0;
    end else if (ce_i) begin
      if (fifo_pop) begin
        fifo_hold_r     <= fifo_out;
        fifo_pop_hold_r <= 1'b1;
      end else if (ref_rise && st_r == ST_DATA && tx_dib_r == 2'h0) begin
        fifo_pop_hold_r <= 1'b0;
      end
    end
  end

  // Receive deserialiser sampled on reference clock rising edges
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_sh_r        <= 8'h00;
      rx_dib_r       <= 2'h0;
      rx_err_r       <= 1'b0;
      rx_act_r       <= 1'b0;
      rx_data_o      <= 8'h00;
      rx_valid_o     <= 1'b0;
      rx_frame_end_o <= 1'b0;
      rx_frame_err_o <= 1'b0;
    end else if (ce_i) begin
      rx_valid_o     <= 1'b0;
      rx_frame_end_o <= 1'b0;
      if (ref_rise) begin
        if (crs_s) begin
          // Only dibits under carrier valid are taken
          rx_act_r <= 1'b1;
          rx_sh_r  <= {rxd_s2_r, rx_sh_r[7:2]};
          rx_dib_r <= rx_dib_r + 2'h1;
          if (rxer_sync_r[1]) begin
            rx_err_r <= 1'b1;
          end
          if (rx_dib_r == 2'h3) begin
            rx_data_o  <= {rxd_s2_r, rx_sh_r[7:2]};
            rx_valid_o <= 1'b1;
          end
        end else if (rx_act_r) begin
          // Carrier gone: report frame end, error if any error cycle seen
          rx_act_r       <= 1'b0;
          rx_dib_r       <= 2'h0;
          rx_frame_end_o <= 1'b1;
          rx_frame_err_o <= rx_err_r | rxer_sync_r[1];
          rx_err_r       <= 1'b0;
        end
      end
    end
  end
endmodule // rmii_mac_side

// ==== tb/rmii_mac_side_sva.sv ====
// Assertions on the ports of the RMII MAC-side port
`timescale 1ns/1ps
module rmii_mac_side_sva (
  input wire       clk_i,
  input wire       rst_i,
  input wire       ref_clk_i,
  input wire       ref_clock_out_o,
  input wire       tx_en_o,
  input wire [1:0] txd_o,
  input wire       carrier_valid_pin_i,
  input wire       rx_error_pin_i,
  input wire       rx_valid_o,
  input wire       rx_frame_end_o,
  input wire       rx_frame_err_o
);
  reg err_seen_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Error seen on the wire inside the current frame
  always @(posedge clk_i) begin
    if (rst_i || rx_frame_end_o) err_seen_r <= 1'b0;
    else if (carrier_valid_pin_i && rx_error_pin_i) err_seen_r <= 1'b1;
  end
  sequence tx_start_s; $rose(tx_en_o); endsequence
  sequence line_idle_s; (!carrier_valid_pin_i) [*8]; endsequence
  ref_out_a: assert property ($rose(ref_clk_i) |-> ##[1:5] $rose(ref_clock_out_o))
    else $error("reference clock out missed");
  tx_first_a: assert property (tx_start_s |-> txd_o == 2'h1)
    else $error("first dibit not preamble");
  tx_hold_a: assert property (tx_start_s |=> tx_en_o [*8])
    else $error("transmit enable dropped early");
  txd_stand_a: assert property ($changed(txd_o) |=> $stable(txd_o) [*5])
    else $error("transmit dibit changed mid period");
  rx_pulse_a: assert property (rx_valid_o |=> (!rx_valid_o) [*8])
    else $error("byte strobes too close");
  rx_quiet_a: assert property (line_idle_s |-> !rx_valid_o)
    else $error("byte delivered without carrier");
  frame_end_a: assert property ($fell(carrier_valid_pin_i) |-> ##[1:16] rx_frame_end_o)
    else $error("frame end missing");
  frame_err_a: assert property (rx_frame_end_o |-> rx_frame_err_o == err_seen_r)
    else $error("frame error flag wrong");
endmodule // rmii_mac_side_sva

// ==== tb/rmii_phy_model.sv ====
// Behavioural PHY on the far side of the RMII port
`timescale 1ns/1ps
module rmii_phy_model (
  input  wire       tx_en_i,
  input  wire [1:0] txd_i,
  output reg        ref_clk_o,
  output reg        carrier_o,
  output reg  [1:0] rxd_o,
  output reg        rx_err_o,
  output reg  [7:0] tx_byte_o,
  output reg        tx_stb_o
);
  reg [7:0] sh;
  integer   n;
  // Free-running reference clock, phase unrelated to the system clock
  initial begin
    {carrier_o, rxd_o, rx_err_o, tx_stb_o, sh, n} = 0;
    ref_clk_o = 1'b0;
    #7;
    forever #40 ref_clk_o = ~ref_clk_o;
  end
  // Collect transmit dibits into bytes, low dibit first
  always @(posedge ref_clk_o) begin
    tx_stb_o <= 1'b0;
    if (tx_en_i) begin
      sh = {txd_i, sh[7:2]};
      n = n + 1;
      if (n == 4) begin
        tx_byte_o <= sh;
        tx_stb_o <= 1'b1;
        n = 0;
      end
    end else n = 0;
  end
  // One received byte as four dibits with carrier held
  task send(input [7:0] b, input e);
    integer i;
    for (i = 0; i < 4; i = i + 1) begin
      @(negedge ref_clk_o);
      carrier_o = 1'b1;
      rxd_o = b[2*i +: 2];
      rx_err_o = e;
    end
  endtask
  // Idle medium: carrier low, data lines keep changing
  task idle;
    @(negedge ref_clk_o);
    carrier_o = 1'b0;
    rx_err_o = 1'b0;
    rxd_o = ~rxd_o;
  endtask
endmodule // rmii_phy_model

// ==== tb/tb_rmii_mac_side.sv ====
// Self-checking bench for the RMII MAC-side port
`timescale 1ns/1ps
module tb_rmii_mac_side;
  reg        clk_i = 1'b0, rst_i = 1'b1, tx_valid_i = 1'b0, tx_last_i = 1'b0, full_seen = 1'b0;
  reg  [7:0] tx_data_i = 8'h00;
  wire       ref_clk_i, ref_clock_out_o, tx_en_o, carrier_valid_pin_i, rx_error_pin_i, tx_ready_o, tx_stb;
  wire       rx_valid_o, rx_frame_end_o, rx_frame_err_o;
  wire [1:0] txd_o, rxd_i;
  wire [7:0] rx_data_o, tx_byte;
  reg  [7:0] exp_tx[$], exp_rx[$], exp_err[$];
  reg [31:0] seed = 32'h05d4;
  integer    n_fail = 0, n_checks = 0, k;
  always #5 clk_i = ~clk_i;
  rmii_mac_side #(.FIFO_DEPTH(8), .FIFO_AW(3)) i_rmii_mac_side (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .ref_clk_i(ref_clk_i), .ref_clock_out_o(ref_clock_out_o), .tx_en_o(tx_en_o), .txd_o(txd_o),
    .carrier_valid_pin_i(carrier_valid_pin_i), .rx_error_pin_i(rx_error_pin_i), .rxd_i(rxd_i),
    .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_last_i(tx_last_i), .tx_ready_o(tx_ready_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_frame_end_o(rx_frame_end_o),
    .rx_frame_err_o(rx_frame_err_o));
  rmii_phy_model i_rmii_phy_model (.tx_en_i(tx_en_o), .txd_i(txd_o), .ref_clk_o(ref_clk_i),
    .carrier_o(carrier_valid_pin_i), .rxd_o(rxd_i), .rx_err_o(rx_error_pin_i), .tx_byte_o(tx_byte),
    .tx_stb_o(tx_stb));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input [7:0] got, input [7:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Offer one byte and hold it until the FIFO takes it
  task put(input [7:0] d, input l);
    integer w;
    #1 tx_data_i = d;
    tx_valid_i = 1'b1;
    tx_last_i = l;
    for (w = 0; tx_ready_o !== 1'b1; w = w + 1) begin
      full_seen = 1'b1;
      if (w > 3000) begin n_fail = n_fail + 1; summarize; end
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
  endtask
  // Send one frame back to back and wait until it has left the wire
  task tx_frame(input integer len);
    integer i;
    for (i = 0; i < 8; i = i + 1) exp_tx.push_back(i < 7 ? 8'h55 : 8'hd5);
    for (i = 0; i < len; i = i + 1) begin
      seed = lfsr(seed);
      exp_tx.push_back(seed[7:0]);
      put(seed[7:0], i == len - 1);
    end
    #1 tx_valid_i = 1'b0;
    tx_last_i = 1'b0;
    for (i = 0; i < 9000 && (tx_en_o !== 1'b0 || exp_tx.size() != 0); i = i + 1) @(posedge clk_i);
    if (i == 9000) begin n_fail = n_fail + 1; summarize; end
  endtask
  // Receive one frame from the PHY, error on byte number bad
  task rx_frame(input integer len, input integer bad);
    integer i;
    for (i = 0; i < len; i = i + 1) begin
      seed = lfsr(seed);
      exp_rx.push_back(seed[7:0]);
      i_rmii_phy_model.send(seed[7:0], i == bad);
    end
    exp_err.push_back(bad < len);
    for (i = 0; i < 4; i = i + 1) i_rmii_phy_model.idle;
  endtask
  // Compare every result with the oldest note
  always @(posedge clk_i) begin
    if (rx_valid_o === 1'b1) check(rx_data_o, exp_rx.pop_front());
    if (rx_frame_end_o === 1'b1) check(rx_frame_err_o, exp_err.pop_front());
  end
  always @(posedge tx_stb) check(tx_byte, exp_tx.pop_front());
  // Main sequence: both directions run at once
  initial begin
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    @(posedge clk_i);
    fork
      begin tx_frame(12); check(full_seen, 1'b1); tx_frame(1); end
      begin rx_frame(5, 9); rx_frame(3, 1); rx_frame(2, 2); end
    join
    for (k = 0; k < 4000 && exp_rx.size() + exp_err.size() != 0; k = k + 1) @(posedge clk_i);
    if (k == 4000) n_fail = n_fail + 1;
    summarize;
  end
endmodule // tb_rmii_mac_side
bind rmii_mac_side rmii_mac_side_sva i_sva (.clk_i, .rst_i, .ref_clk_i, .ref_clock_out_o, .tx_en_o, .txd_o,
  .carrier_valid_pin_i, .rx_error_pin_i, .rx_valid_o, .rx_frame_end_o, .rx_frame_err_o);
